// >>> src/iamb_pkg.sv
package iamb_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] IAMB_OFF_MASK   = 4'h0;
  localparam logic [3:0] IAMB_OFF_ADDR   = 4'h4;
  localparam logic [3:0] IAMB_OFF_CTRL   = 4'h8;
  localparam logic [3:0] IAMB_OFF_STATUS = 4'hC;

  localparam logic [7:0] IAMB_MASK_RST = 8'hFF;
  localparam logic [7:0] IAMB_ADDR_RST = 8'h00;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int IAMB_CTRL_MODE_LSB = 0;
  localparam int IAMB_CTRL_ADDRESS_HOLD_ENABLE     = 4;
  localparam int IAMB_CTRL_DATA_HOLD_ENABLE     = 5;
  localparam int IAMB_CTRL_RUN      = 6;
  localparam logic [6:0] IAMB_CTRL_RST = 7'h00;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int IAMB_ST_HI_PEND = 0;
  localparam int IAMB_ST_MATCH   = 1;
  localparam int IAMB_ST_ACKTIME = 2;
  localparam int IAMB_ST_SCL     = 3;

  // ---------------------------------------------------------------
  // mode codes and fixed patterns
  // ---------------------------------------------------------------
  localparam logic [3:0] IAMB_MODE_S7    = 4'h6;
  localparam logic [3:0] IAMB_MODE_S7SP  = 4'hE;
  localparam logic [3:0] IAMB_MODE_S10   = 4'h7;
  localparam logic [3:0] IAMB_MODE_S10SP = 4'hF;
  localparam logic [3:0] IAMB_MODE_MST   = 4'h8;
  localparam logic [4:0] IAMB_HI_PREFIX  = 5'h1E;

  // serial clock period is this many oscillator periods per divider step
  localparam int IAMB_SCL_MULT = 4;

  typedef struct packed {
    logic       run;
    logic       data_hold_enable;
    logic       address_hold_enable;
    logic [3:0] port_mode_select;
  } iamb_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } iamb_rx_s;

endpackage

// >>> src/iamb_top.sv
`timescale 1ns/10ps
`default_nettype none

module iamb_top
  import iamb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [3:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire iamb_rx_s    rx_addr,
  input  wire logic        ack_phase,
  output logic             addr_match,
  output logic             hi_byte_match,
  output logic             acknowledge_time_status,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic masked_eq(
    input logic [7:0] rx,
    input logic [7:0] own,
    input logic [7:0] msk
  );
    masked_eq = ((rx ^ own) & msk) == 8'h00;
  endfunction

  function automatic logic is_ten_bit(input logic [3:0] mode);
    is_ten_bit = (mode == IAMB_MODE_S10) || (mode == IAMB_MODE_S10SP);
  endfunction

  function automatic logic is_seven_bit(input logic [3:0] mode);
    is_seven_bit = (mode == IAMB_MODE_S7) || (mode == IAMB_MODE_S7SP);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  mask_bits_r;
  logic [7:0]  own_addr_r;
  iamb_ctrl_s  ctrl_r;
  logic [31:0] prdata_r;
  logic        hi_pend_r;
  logic        match_r;
  logic        addr_match_r;
  logic        hi_match_r;
  logic        ack_time_r;
  logic        scl_meta_r;
  logic        scl_sync_r;
  logic        scl_drive_low_r;
  logic [9:0]  half_cnt_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable;
  wire hit_mask   = paddr == IAMB_OFF_MASK;
  wire hit_addr   = paddr == IAMB_OFF_ADDR;
  wire hit_ctrl   = paddr == IAMB_OFF_CTRL;
  wire hit_status = paddr == IAMB_OFF_STATUS;
  wire hit_any    = hit_mask | hit_addr | hit_ctrl | hit_status;
  wire wr_en      = access_ph & pwrite & hit_any;

  assign pready  = access_ph;
  assign pslverr = access_ph & ~hit_any;

  wire [31:0] status_word = {28'h0000000,
                             scl_sync_r,
                             ack_time_r,
                             match_r,
                             hi_pend_r};

  wire [31:0] rd_word = hit_mask   ? {24'h000000, mask_bits_r} :
                        hit_addr   ? {24'h000000, own_addr_r} :
                        hit_ctrl   ? {25'h0000000, ctrl_r} :
                        hit_status ? status_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata = prdata_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_bits_r <= IAMB_MASK_RST;
      own_addr_r  <= IAMB_ADDR_RST;
      ctrl_r      <= IAMB_CTRL_RST;
    end else if (wr_en) begin
      if (hit_mask) begin
        mask_bits_r <= pwdata[7:0];
      end
      if (hit_addr) begin
        own_addr_r <= pwdata[7:0];
      end
      if (hit_ctrl) begin
        ctrl_r <= pwdata[6:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire [3:0] mode     = ctrl_r.port_mode_select;
  wire       mode_s10 = is_ten_bit(mode);
  wire       mode_s7  = is_seven_bit(mode);
  wire       mode_mst = mode == IAMB_MODE_MST;

  // ---------------------------------------------------------------
  // address comparison
  // ---------------------------------------------------------------
  // bit 0 of the mask only counts in 10-bit modes
  wire [7:0] mask_7 = {mask_bits_r[7:1], 1'b0};
  wire [7:0] mask_10_lo = mask_bits_r;

  // 7-bit: register bits 7..1 are the address, bit 0 is r/w
  wire cmp_7 = masked_eq(rx_addr.data, own_addr_r, mask_7);

  // 10-bit high byte: fixed prefix in hardware, bits 2..1 masked
  wire prefix_ok = rx_addr.data[7:3] == IAMB_HI_PREFIX;
  wire [7:0] mask_10_hi = {5'h00, mask_bits_r[2:1], 1'b0};
  wire cmp_10_hi = prefix_ok &
                   masked_eq(rx_addr.data, own_addr_r, mask_10_hi);

  // 10-bit low byte: all eight register bits
  wire cmp_10_lo = masked_eq(rx_addr.data, own_addr_r, mask_10_lo);

  wire take_first = rx_addr.valid & rx_addr.first;
  wire take_next  = rx_addr.valid & ~rx_addr.first;

  wire full_match_7   = take_first & mode_s7 & cmp_7;
  wire hi_match_10    = take_first & mode_s10 & cmp_10_hi;
  wire full_match_10  = take_next & mode_s10 & hi_pend_r & cmp_10_lo;
  wire full_match_nxt = full_match_7 | full_match_10;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_pend_r <= 1'b0;
    end else if (take_first) begin
      hi_pend_r <= hi_match_10;
    end else if (take_next || !mode_s10) begin
      hi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      match_r <= 1'b0;
    end else if (full_match_nxt) begin
      match_r <= 1'b1;
    end else if (take_first || !(mode_s7 || mode_s10)) begin
      match_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_match_r <= 1'b0;
      hi_match_r   <= 1'b0;
    end else begin
      addr_match_r <= full_match_nxt;
      hi_match_r   <= hi_match_10;
    end
  end

  assign addr_match    = addr_match_r;
  assign hi_byte_match = hi_match_r;

  // ---------------------------------------------------------------
  // acknowledge-time status
  // ---------------------------------------------------------------
  wire hold_on = ctrl_r.address_hold_enable | ctrl_r.data_hold_enable;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_time_r <= 1'b0;
    end else begin
      ack_time_r <= ack_phase & hold_on;
    end
  end

  assign acknowledge_time_status = ack_time_r;

  // ---------------------------------------------------------------
  // serial clock pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
    end else begin
      scl_meta_r <= serial_clock_pin_in;
      scl_sync_r <= scl_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // master serial clock generator
  // ---------------------------------------------------------------
  // each half lasts 2*(divider+1) clocks, full period 4*(divider+1)
  wire [9:0] half_len = 10'((IAMB_SCL_MULT / 2) * (int'(own_addr_r) + 1));
  wire       gen_on   = mode_mst & ctrl_r.run;
  wire       half_end = half_cnt_r == half_len - 10'h001;
  // a stretching slave holds the line low during our high half;
  // the first two counts of a high half are not judged, since the
  // synchroniser still shows the low level we released (keeps 4*(D+1))
  wire       sync_settled = half_cnt_r >= 10'h002;
  wire       stretched    = ~scl_drive_low_r & ~scl_sync_r & sync_settled;

  always_ff @(posedge clk) begin
    if (sys_rst || !gen_on) begin
      half_cnt_r <= 10'h000;
    end else if (half_end) begin
      half_cnt_r <= 10'h000;
    end else if (!stretched) begin
      half_cnt_r <= half_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !gen_on) begin
      scl_drive_low_r <= 1'b0;
    end else if (half_end) begin
      scl_drive_low_r <= ~scl_drive_low_r;
    end
  end

  // open drain: only ever pulls low
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe  = scl_drive_low_r;

endmodule

`default_nettype wire

// >>> bench/iamb_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module iamb_top_monitor
  import iamb_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [3:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire iamb_rx_s    rx_addr,
  input wire logic        ack_phase,
  input wire logic        addr_match,
  input wire logic        hi_byte_match,
  input wire logic        acknowledge_time_status,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------
  // register shadows
  // ------
  logic [7:0] own_r, msk_r;
  logic [6:0] ctl_r;
  logic [9:0] hi_r;
  logic       pend_r;
  wire        wr  = psel && penable && pwrite;
  wire        rv  = rx_addr.valid;
  wire        s7  = ctl_r[2:0] == 3'h6;
  wire        s10 = ctl_r[2:0] == 3'h7;
  wire        gen = ctl_r[3:0] == IAMB_MODE_MST && ctl_r[IAMB_CTRL_RUN];
  wire [7:0]  dif = (rx_addr.data ^ own_r) & msk_r;
  wire        m7  = (dif & 8'hFE) == 8'h00;
  wire        mh  = rx_addr.data[7:3] == IAMB_HI_PREFIX && (dif & 8'h06) == 8'h00;
  wire        ml  = dif == 8'h00;
  wire        ack = ack_phase && (ctl_r[4] || ctl_r[5]);
  always_ff @(posedge clk) begin
    own_r <= sys_rst ? IAMB_ADDR_RST : wr && paddr == IAMB_OFF_ADDR ? pwdata[7:0] : own_r;
    msk_r <= sys_rst ? IAMB_MASK_RST : wr && paddr == IAMB_OFF_MASK ? pwdata[7:0] : msk_r;
    ctl_r <= sys_rst ? IAMB_CTRL_RST : wr && paddr == IAMB_OFF_CTRL ? pwdata[6:0] : ctl_r;
    pend_r <= sys_rst || rv ? 1'h0 : hi_byte_match || pend_r;
    hi_r <= sys_rst || !serial_clock_pin_oe ? 10'h000 : hi_r + 10'h001;
  end
  AST_M7: assert property (rv && rx_addr.first && s7 |=> addr_match == $past(m7))
    else $error("bad 7-bit match");
  AST_HI: assert property (rv && rx_addr.first && s10 |=> hi_byte_match == $past(mh))
    else $error("bad high byte match");
  AST_LO: assert property (rv && !rx_addr.first && s10 && pend_r |=> addr_match == $past(ml))
    else $error("bad low byte match");
  AST_NONE: assert property (!(rv && (s7 || s10)) |=> !addr_match && !hi_byte_match)
    else $error("match without slave byte");
  AST_ACK: assert property (acknowledge_time_status == $past(ack))
    else $error("bad ack time status");
  AST_OD: assert property (serial_clock_pin_out == 1'h0)
    else $error("clock pin driven high");
  AST_OFF: assert property (!gen |=> !serial_clock_pin_oe)
    else $error("clock runs while stopped");
  AST_HALF: assert property ($fell(serial_clock_pin_oe) && gen && $past(gen)
    |-> hi_r == 2 * (own_r + 1)) else $error("bad clock low half");
endmodule
bind iamb_top iamb_top_monitor u_iamb_top_monitor (.*);
`default_nettype wire

// >>> bench/iamb_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module iamb_bus_model (
  input  wire logic oe,
  input  wire logic stretch,
  input  wire logic frame,
  output logic      scl
);
  logic ext_clk = 1'h1;
  // far master clock, still outside frames
  always #80 ext_clk = frame ? !ext_clk : 1'h1;
  // pulled-up open-drain wire
  assign scl = !(oe || stretch || !ext_clk);
endmodule
`default_nettype wire

// >>> bench/iamb_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module iamb_top_tb;
  import iamb_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic ack_phase = 1'h0, stretch = 1'h0, frame = 1'h0, vd = 1'h0, pend;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, addr_match, hi_byte_match, acknowledge_time_status;
  logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
  iamb_rx_s rx_addr = '0;
  logic [32:0] qr[$];
  logic [1:0] qm[$];
  logic [7:0] own, msk, d;
  logic [3:0] md[4] = '{IAMB_MODE_S7, IAMB_MODE_S7SP, IAMB_MODE_S10, IAMB_MODE_S10SP};
  integer seed = 11296, failures = 0, samples_checked = 0, n;
  realtime t0;
  always #10 clk = !clk;
  iamb_top u_iamb_top (.*);
  iamb_bus_model u_iamb_bus_model (.oe(serial_clock_pin_oe), .stretch, .frame,
                                   .scl(serial_clock_pin_in));
  // ------
  // tasks
  // ------
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [32:0] e);
    qr.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic send(input logic f, input logic [7:0] v, input logic [1:0] e);
    @(posedge clk);
    rx_addr <= '{1'h1, f, v};
    ack_phase <= 1'($random(seed));
    qm.push_back(e);
    @(posedge clk);
    rx_addr.valid <= 1'h0;
  endtask
  always @(posedge clk) begin
    vd <= rx_addr.valid;
    if (vd) check({hi_byte_match, addr_match}, qm.pop_front());
    if (psel && penable && !pwrite) check({pslverr, prdata}, qr.pop_front());
  end
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rd(IAMB_OFF_MASK, {25'h0, IAMB_MASK_RST});
    rd(IAMB_OFF_ADDR, {25'h0, IAMB_ADDR_RST});
    rd(4'h2, {1'h1, 32'h0});
    frame <= 1'h1;
    foreach (md[m]) begin
      for (int k = 0; k < 12; k++) begin
        own = 8'($random(seed));
        msk = 8'($random(seed) | $random(seed));
        d = own ^ 8'($random(seed) & $random(seed));
        apb(1'h1, IAMB_OFF_ADDR, {24'h0, own});
        apb(1'h1, IAMB_OFF_MASK, {24'h0, msk});
        apb(1'h1, IAMB_OFF_CTRL, {26'h0, 2'($random(seed)), md[m]});
        rd(IAMB_OFF_ADDR, {25'h0, own});
        if (!md[m][0]) send(1'h1, d, {1'h0, ((d ^ own) & msk & 8'hFE) == 8'h00});
        else begin
          if (k % 4 != 0) d[7:3] = IAMB_HI_PREFIX;
          pend = d[7:3] == IAMB_HI_PREFIX && ((d ^ own) & msk & 8'h06) == 8'h00;
          send(1'h1, d, {pend, 1'h0});
          d = own ^ 8'($random(seed) & $random(seed));
          send(1'h0, d, {1'h0, pend && ((d ^ own) & msk) == 8'h00});
        end
      end
    end
    apb(1'h1, IAMB_OFF_CTRL, {28'h0, IAMB_MODE_MST});
    send(1'h1, own, 2'h0);
    frame <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      d = i == 0 ? 8'h00 : i == 1 ? 8'h06 : 8'hFF;
      apb(1'h1, IAMB_OFF_CTRL, 32'h0);
      apb(1'h1, IAMB_OFF_ADDR, {24'h0, d});
      apb(1'h1, IAMB_OFF_CTRL, {26'h1, 2'h0, IAMB_MODE_MST});
      @(posedge serial_clock_pin_oe);
      t0 = $realtime;
      @(posedge serial_clock_pin_oe);
      n = ($realtime - t0) / 20;
      check(33'(n), 33'(4 * (d + 1)));
      stretch <= 1'h1;
      repeat (40) @(posedge clk);
      stretch <= 1'h0;
    end
    conclude();
  end
endmodule
`default_nettype wire
